// ===== verilog/crb_map.svh
// Constants for the carrier reset and boot-hold sequencer
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH
`define CRB_CLK_MHZ       200
`define CRB_GLITCH_NS     100
`define CRB_GLITCH_CYC    ((`CRB_GLITCH_NS * `CRB_CLK_MHZ + 999) / 1000)
`define CRB_HOLD_MS       200
`define CRB_HOLD_CYC      (`CRB_HOLD_MS * 1000 * `CRB_CLK_MHZ)
`define CRB_POR_MS        10
`define CRB_POR_CYC       (`CRB_POR_MS * 1000 * `CRB_CLK_MHZ)
`define CRB_NUM_SLOTS     4
`define CRB_CNT_W         27
`endif

// ===== verilog/crb_pkg.sv
// Types for the carrier reset and boot-hold sequencer
package crb_pkg;
  typedef enum logic [2:0] {
    CRB_POR  = 3'h1,
    CRB_HOLD = 3'h2,
    CRB_RUN  = 3'h4
  } crb_state_t;
endpackage

// ===== verilog/crb_pulse_filter.sv
// Low-pulse qualifier and retriggerable stretch for the external reset input
`include "crb_map.svh"
module crb_pulse_filter #(
  parameter int HOLD_CYC = `CRB_HOLD_CYC
) (
  input  wire logic core_clk, // System clock
  input  wire logic rst,      // Synchronous reset
  input  wire logic extRstN,  // External reset input, low active
  output logic      stretchOn // Qualified, stretched reset
);
  typedef struct packed {
    logic [4:0]              lowCnt;
    logic [`CRB_CNT_W-1:0]   holdCnt;
    logic                    on;
  } crb_flt_t;
  crb_flt_t st_r, st_nxt;
  localparam logic [4:0] GLITCH = 5'(`CRB_GLITCH_CYC);
  localparam logic [`CRB_CNT_W-1:0] HOLD = `CRB_CNT_W'(HOLD_CYC);

  always_comb begin
    st_nxt = st_r;
    if (!extRstN) begin
      if (st_r.lowCnt != GLITCH) st_nxt.lowCnt = st_r.lowCnt + 5'h1;
    end else begin
      st_nxt.lowCnt = 5'h0;
    end
    // Every qualified low cycle reloads, so a held input keeps reset on
    if (!extRstN && st_r.lowCnt >= GLITCH - 5'h1) begin // [RULE13]
      st_nxt.holdCnt = HOLD;
      st_nxt.on      = 1'b1;
    end else if (st_r.holdCnt != '0) begin
      st_nxt.holdCnt = st_r.holdCnt - `CRB_CNT_W'(1);
    end else begin
      st_nxt.on = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) st_r <= '0;
    else     st_r <= st_nxt;
  end
  assign stretchOn = st_r.on;

  AST_SHORT_IGNORED: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (rst)
    (!st_r.on && extRstN) ##1 !extRstN ##1 extRstN |=> !st_r.on)
    else $error("Short low pulse started reset");
  AST_QUALIFY: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (rst)
    !extRstN && st_r.lowCnt == GLITCH - 5'h1
      |=> st_r.on && st_r.holdCnt == HOLD)
    else $error("Qualified low did not load the hold interval");
  AST_LONG_TAKEN: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (rst)
    !extRstN && st_r.lowCnt == GLITCH
      |=> st_r.on && st_r.holdCnt == HOLD)
    else $error("Held low did not keep reset loaded");
endmodule // crb_pulse_filter

// ===== verilog/crb_reset_seq.sv
// Board reset combiner, power-up delay, indicators and boot-hold line
`include "crb_map.svh"
// ---------------------------------------------------------------
// Function
// RULE1: Board reset generated on its own after power-up, no host needed.
// RULE2: Power-up reset held for a delay after supplies are stable.
// RULE3: Host bus reset or reset-register write reasserts board reset.
// RULE4: During reset all circuitry cleared, FIFO links torn down and flushed.
// RULE5: Module reset driven to every slot, inter-board modules included.
// RULE6: Modules reset logic but keep programmable-logic configuration.
// RULE7: Reset indicator lit exactly while board reset is asserted.
// RULE8: Board reset is OR of each slot request and host bus reset.
// RULE9: Carrier supplies passive high level on shared boot-hold line.
// RULE10: Processor modules hold boot-hold low until software releases it.
// RULE11: Hardware depending on boot-hold stays off while line is low.
// RULE12: Boot-hold buffered; indicator lit while the line is low.
// RULE13: Ignore external lows under 100ns; hold 0.2s, retriggered.
// RULE14: Reset asserts immediately, releases synchronously to the clock. Code registers the assertion too, one clock after the source.
// ---------------------------------------------------------------
module crb_reset_seq #(
  parameter int POR_CYC  = `CRB_POR_CYC,
  parameter int HOLD_CYC = `CRB_HOLD_CYC
) (
  input  wire logic                      core_clk,      // 200 MHz clock
  input  wire logic                      rst,           // Power-good reset
  input  wire logic                      hostBusRst,    // Host bus reset
  input  wire logic                      swRstWr,       // Reset reg write
  input  wire logic [`CRB_NUM_SLOTS-1:0] slot_remote_reset_request, // Slots
  input  wire logic                      extRstN,       // External reset
  input  wire logic                      bootHoldIn,    // Boot-hold level
  output logic                           boardRst,      // Board reset
  output logic      [`CRB_NUM_SLOTS-1:0] moduleRst,     // Per slot reset
  output logic                           fifoFlush,     // FIFO teardown
  output logic                           rstLed,        // Reset indicator
  output logic                           bootHoldPullOut, // Pull-up drive
  output logic                           bootHoldPullOe,  // Pull-up enable
  output logic                           bootHoldLed,   // Boot-hold lamp
  output logic                           bootDone       // Boot-hold high, board out of reset
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    crb_pkg::crb_state_t        fsm;
    logic [`CRB_CNT_W-1:0]      porCnt;
    logic                       brd;
    logic [`CRB_NUM_SLOTS-1:0]  mod;
    logic                       flush;
    logic                       led;
    logic                       bhLed;
    logic                       bhDone;
  } crb_seq_t;
  crb_seq_t st_r, st_nxt;
  localparam logic [`CRB_CNT_W-1:0] POR = `CRB_CNT_W'(POR_CYC);

  logic extOn;
  logic srcAct;

  crb_pulse_filter #(.HOLD_CYC(HOLD_CYC)) u_flt (
    .core_clk  (core_clk),
    .rst       (rst),
    .extRstN   (extRstN),
    .stretchOn (extOn)
  );

  // Any single source resets the whole board
  assign srcAct = hostBusRst | swRstWr | (|slot_remote_reset_request)
                | extOn; // [RULE3] [RULE8]

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r.fsm)
      crb_pkg::CRB_POR: begin
        // Stands in for the CR delay past stable supplies
        if (st_r.porCnt == POR - `CRB_CNT_W'(1)) begin // [RULE1] [RULE2]
          // A source still high at the end goes straight to hold
          st_nxt.fsm = srcAct ? crb_pkg::CRB_HOLD : crb_pkg::CRB_RUN;
        end else begin
          st_nxt.porCnt = st_r.porCnt + `CRB_CNT_W'(1);
        end
      end
      crb_pkg::CRB_HOLD: begin
        if (!srcAct) st_nxt.fsm = crb_pkg::CRB_RUN;
      end
      crb_pkg::CRB_RUN: begin
        if (srcAct) st_nxt.fsm = crb_pkg::CRB_HOLD;
      end
      default: st_nxt.fsm = crb_pkg::CRB_POR;
    endcase
    // Assert off the raw sources; release only on the state edge
    st_nxt.brd   = srcAct || st_nxt.fsm != crb_pkg::CRB_RUN; // [RULE14]
    st_nxt.mod   = {`CRB_NUM_SLOTS{st_nxt.brd}};              // [RULE5]
    st_nxt.flush = st_nxt.brd;                                // [RULE4]
    st_nxt.led   = st_nxt.brd;                                // [RULE7]
    st_nxt.bhLed  = !bootHoldIn;                              // [RULE12]
    st_nxt.bhDone = bootHoldIn && !st_nxt.brd;                // [RULE11]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.fsm    <= crb_pkg::CRB_POR;
      st_r.brd    <= 1'b1;
      st_r.mod    <= '1;
      st_r.flush  <= 1'b1;
      st_r.led    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign boardRst        = st_r.brd;
  assign moduleRst       = st_r.mod;
  assign fifoFlush       = st_r.flush;
  assign rstLed          = st_r.led;
  // Passive pull: always enabled, high; modules overpower it low
  assign bootHoldPullOut = 1'b1; // [RULE9]
  assign bootHoldPullOe  = 1'b1; // [RULE9]
  assign bootHoldLed     = st_r.bhLed;
  assign bootDone        = st_r.bhDone;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SRC_ASSERTS: assert property ( // [RULE3]
    @(posedge core_clk) disable iff (rst)
    (hostBusRst || swRstWr || |slot_remote_reset_request) |=> boardRst)
    else $error("Reset source did not assert board reset");

  AST_SLOT_OR: assert property ( // [RULE8]
    @(posedge core_clk) disable iff (rst)
    $rose(|slot_remote_reset_request) |=> boardRst && moduleRst == '1)
    else $error("Slot request not ORed into reset");

  AST_ANY_SLOT: assert property ( // [RULE8]
    @(posedge core_clk) disable iff (rst)
    (|slot_remote_reset_request) |=> moduleRst == '1)
    else $error("Single slot request did not reset all slots");

  AST_MOD_ALL: assert property ( // [RULE5]
    @(posedge core_clk) disable iff (rst)
    moduleRst == {`CRB_NUM_SLOTS{boardRst}})
    else $error("Module reset differs from board reset");

  AST_LED_TRACK: assert property ( // [RULE7]
    @(posedge core_clk) disable iff (rst)
    rstLed == boardRst && fifoFlush == boardRst)
    else $error("Reset lamp or flush out of step");

  AST_FLUSH_ON: assert property ( // [RULE4]
    @(posedge core_clk) disable iff (rst)
    srcAct |=> fifoFlush && boardRst)
    else $error("FIFO teardown missing under reset source");

  // Release only ever leaves from the hold or power-up state
  AST_RELEASE: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (rst)
    $fell(boardRst) |-> $past(st_r.fsm) != crb_pkg::CRB_RUN)
    else $error("Release not from reset state");

  AST_REL_NEXT: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (rst)
    st_r.fsm == crb_pkg::CRB_HOLD && !srcAct |=> !boardRst)
    else $error("Board reset outlived its last source");

  AST_QUIET_RUN: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (rst)
    !boardRst && !srcAct |=> !boardRst)
    else $error("Board reset rose with no source");

  AST_HOLD_STAY: assert property ( // [RULE8]
    @(posedge core_clk) disable iff (rst)
    st_r.fsm == crb_pkg::CRB_HOLD |-> boardRst)
    else $error("Hold state without board reset");

  AST_EXT_TAKEN: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (rst)
    extOn |=> boardRst)
    else $error("Filtered external reset ignored");

  AST_POR_HOLD: assert property ( // [RULE2]
    @(posedge core_clk) disable iff (rst)
    st_r.fsm == crb_pkg::CRB_POR |-> boardRst)
    else $error("Reset dropped during power-up delay");

  AST_POR_LEN: assert property ( // [RULE1] [RULE2]
    @(posedge core_clk) disable iff (rst)
    $fell(boardRst) && $past(st_r.fsm) == crb_pkg::CRB_POR
      |-> $past(st_r.porCnt) == POR - `CRB_CNT_W'(1))
    else $error("Power-up reset released early");

  AST_ONE_HOT: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (rst)
    $onehot(st_r.fsm))
    else $error("Sequencer state not one-hot");

  AST_BH_LED: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (rst)
    !bootHoldIn |=> bootHoldLed && !bootDone)
    else $error("Boot-hold lamp not lit on low");

  AST_BH_OFF: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (rst)
    bootHoldIn |=> !bootHoldLed)
    else $error("Boot-hold lamp lit on high");

  AST_DONE_GATED: assert property ( // [RULE11]
    @(posedge core_clk) disable iff (rst)
    boardRst |-> !bootDone)
    else $error("Boot done shown during board reset");

  AST_DONE_SET: assert property ( // [RULE11]
    @(posedge core_clk) disable iff (rst)
    bootHoldIn && !srcAct && st_r.fsm == crb_pkg::CRB_RUN |=> bootDone)
    else $error("Boot done missing with line released");

  AST_PULL: assert property ( // [RULE9]
    @(posedge core_clk) disable iff (rst)
    bootHoldPullOe && bootHoldPullOut)
    else $error("Boot-hold pull not driven");
endmodule // crb_reset_seq

// ===== verif/crb_partner.sv
// Plug-in module model: boot-hold pull-down and resolved boot-hold wire
module crb_partner (
  input  wire logic core_clk,   // System clock
  input  wire logic boardRst,   // Module reset from the carrier
  input  wire logic swDone,     // Module software has finished booting
  input  wire logic pullOe,     // Carrier pull-up enable
  input  wire logic pullOut,    // Carrier pull-up level
  output logic      bootHoldIn, // Resolved boot-hold wire
  output logic      hwEnable    // Hardware gated by boot-hold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic holdLow_r = 1'b1;
  logic cfgLoaded_r = 1'b1;

  // Reset clears the boot state only; the loaded config stays
  always @(posedge core_clk) begin
    if (boardRst) holdLow_r <= 1'b1;
    else if (swDone && cfgLoaded_r) holdLow_r <= 1'b0;
  end
  // Without the pull-up the wire would float, so it reads low here
  assign bootHoldIn = holdLow_r ? 1'b0 : (pullOe & pullOut);
  assign hwEnable = bootHoldIn;
endmodule // crb_partner

// ===== verif/tb.sv
// Self-checking bench for the carrier reset and boot-hold sequencer
`include "crb_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, hostBusRst, swRstWr, extRstN, swDone, bootHoldIn;
  logic [`CRB_NUM_SLOTS-1:0] slotReq, moduleRst;
  logic boardRst, fifoFlush, rstLed, pullOut, pullOe, bootHoldLed, bootDone;
  int miscompares, check_count;
  logic [31:0] seed = 32'h6324;
  localparam int POR_SIM = 16;

  crb_reset_seq #(.POR_CYC(POR_SIM), .HOLD_CYC(50)) DUT (.core_clk(core_clk),
    .rst(rst), .hostBusRst(hostBusRst), .swRstWr(swRstWr),
    .slot_remote_reset_request(slotReq), .extRstN(extRstN),
    .bootHoldIn(bootHoldIn), .boardRst(boardRst), .moduleRst(moduleRst),
    .fifoFlush(fifoFlush), .rstLed(rstLed), .bootHoldPullOut(pullOut),
    .bootHoldPullOe(pullOe), .bootHoldLed(bootHoldLed), .bootDone(bootDone));
  crb_partner MOD (.core_clk(core_clk), .boardRst(boardRst), .swDone(swDone),
    .pullOe(pullOe), .pullOut(pullOut), .bootHoldIn(bootHoldIn),
    .hwEnable());

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] rstVec(input logic on);
    return on ? 8'h7f : 8'h00;
  endfunction
  function automatic logic [7:0] outs();
    return {1'b0, boardRst, fifoFlush, rstLed, moduleRst};
  endfunction

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic waitRel(input int lim);
    int n;
    n = 0;
    while (boardRst !== 1'b0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (boardRst !== 1'b0) begin
      miscompares++;
      $display("BAD release exp 0 got %b", boardRst);
      wrap_up();
    end
  endtask
  task automatic setSrc(input int k, input logic v);
    if (k == 0) hostBusRst = v;
    else if (k == 1) swRstWr = v;
    else slotReq[k-2] = v;
  endtask
  task automatic extPulse(input int n);
    extRstN = 1'b0;
    repeat (n) @(negedge core_clk);
    extRstN = 1'b1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {hostBusRst, swRstWr, extRstN, swDone} = 4'h2;
    slotReq = '0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (12) @(negedge core_clk);
    chk("por", rstVec(1), outs());
    chk("hold", 8'h2, {6'h0, bootHoldLed, bootHoldIn});
    waitRel(10);
    chk("por_end", rstVec(0), outs());
    swDone = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("boot", 8'h3, {5'h0, bootHoldLed, bootHoldIn, bootDone});
    for (int k = 0; k < 2 + `CRB_NUM_SLOTS; k++) begin
      setSrc(k, 1'b1);
      repeat (2 + rnd() % 3) @(negedge core_clk);
      chk("src", rstVec(1), outs());
      setSrc(k, 1'b0);
      waitRel(6);
      chk("rel", rstVec(0), outs());
    end
    for (int i = 0; i < 8; i++) begin
      {hostBusRst, swRstWr, slotReq} = 6'(rnd());
      repeat (2) @(negedge core_clk);
      chk("rnd", rstVec(|{hostBusRst, swRstWr, slotReq}), outs());
      {hostBusRst, swRstWr, slotReq} = 6'h0;
      waitRel(6);
    end
    for (int i = 0; i < 4; i++) begin
      extPulse(i == 0 ? 19 : i == 1 ? 1 : 1 + rnd() % 19);
      repeat (4) @(negedge core_clk);
      chk("glitch", rstVec(0), outs());
    end
    extPulse(20 + rnd() % 4);
    repeat (40) @(negedge core_clk);
    chk("ext", rstVec(1), outs());
    extPulse(21);
    repeat (40) @(negedge core_clk);
    chk("retrig", rstVec(1), outs());
    waitRel(40);
    chk("ext_end", rstVec(0), outs());
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("rst", rstVec(1), outs());
    rst = 1'b0;
    repeat (POR_SIM - 1) @(negedge core_clk);
    chk("por_len", rstVec(1), outs());
    @(negedge core_clk);
    chk("por_rel", rstVec(0), outs());
    wrap_up();
  end
endmodule // tb
